// ===== include/vrm_regs.svh
`ifndef VRM_REGS_SVH
`define VRM_REGS_SVH
// Word indices; byte address is four times the index.
`define IDX_CMD 4'h0
`define IDX_STATUS 4'h1
`define IDX_FLAGS 4'h2
`define IDX_SP 4'h3
`define IDX_IP 4'h4
`define IDX_CS 4'h5
`define IDX_SS 4'h6
`define IDX_DS 4'h7
`define IDX_ES 4'h8
`define IDX_FS 4'h9
`define IDX_GS 4'hA
`define IDX_GATE 4'hB
`define IDX_GATE_IP 4'hC
`define IDX_L0_SS 4'hD
`define IDX_L0_SP 4'hE
`define IDX_AUX 4'hF
// Address bit 6 selects the stack window, bit 7 is unmapped space.
`define ADDR_STACK_BIT 6
`define ADDR_ERR_BIT 7
// Command field of the command register.
`define CMD_EVENT 3'h1
`define CMD_INTERRUPT_RETURN_INSTR 3'h2
`define CMD_TASK 3'h3
`define CMD_FLAGS_PUSH_INSTR 3'h4
`define CMD_FLAGS_POP_INSTR 3'h5
`define CMD_SOFT_INT 3'h6
`define CMD_INT_GATE 3
`define CMD_OP32 4
// Flag word bit positions.
`define FL_TF 8
`define FL_IF 9
`define FL_IO_PRIV_LEVEL 13:12
`define FL_NT 14
`define FL_VM 17
`define FLAGS_RST 32'h00000002
// Gate register fields.
`define GATE_SEL 15:0
`define GATE_DPL 17:16
`define GATE_CONF 18
// Stack word steps.
`define STK_STEP 32'h00000004
`define TASK_IMG_BASE 4'hC
`define PUSH_LAST 4'h9
`define PUSH_NONVM 4'h7
`define NULL_STEP 4'h4
`define RESP_OK 2'h0
`define RESP_ERR 2'h2
`endif

// ===== include/vrm_pkg.sv
package vrm_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN} seq_state_t;
  typedef struct packed {
    seq_state_t st;
    logic [3:0] step;
    logic [1:0] current_priv_level;
    logic fault;
    logic [31:0] tmp_flags;
    logic [31:0] old_ss;
    logic [31:0] old_sp;
    logic [15:0][31:0] rf;
    logic [15:0][31:0] stk;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic berr;
    logic rvalid;
    logic rerr;
    logic [31:0] rdata;
  } core_t;
endpackage

// ===== src/vrm_transition.sv
`timescale 1ns/10ps
`include "vrm_regs.svh"

// Register map. Every register is one 32-bit word; its byte address is
// four times its index, and byte strobes are honoured on every write except to index 1, where a clear low strobe sets the level to 0.
// Index 0 is the command word. Bits 2:0 pick the sequence, bit 3 marks an
// interrupt gate and bit 4 asks for a 32-bit operand size.
// Index 1 reads back the status word. Bits 1:0 give the current level,
// bit 2 the live mode flag, bit 3 the fault flag, bit 4 busy and bit 5
// real-style segment loads.
// A write to index 1 changes only the current level. Software uses it to
// place the block at a chosen level before a return or a switch.
// Index 2 is the flag word, index 3 the stack pointer and index 4 the
// instruction pointer.
// Indices 5 to 10 hold the code, stack, data, extra, fourth and fifth
// segment images, in that order.
// Index 11 is the gate word: selector in bits 15:0, target level in bits
// 17:16 and the conforming bit in bit 18.
// Index 12 is the gate entry pointer, and indices 13 and 14 give the
// level-0 stack segment and pointer that an exit switches to.
// Index 15 is the auxiliary word. It carries a task flag image in, the
// pushed flag image out and the fault code out.
// Address bit 6 opens a window onto a stack memory of sixteen words,
// indexed by stack pointer bits 5:2. The stack therefore wraps every
// sixty-four bytes, and a deeper frame overwrites its own oldest words.
// Address bit 7 is unmapped space. Reads there return zero and writes are
// dropped, both with an error response.
// Bus timing. A read answers one cycle after its address is taken. A
// write answers two cycles after the later of its address and its data,
// and a second write waits in the holding registers until the first
// response has been accepted.
// Sequence timing, counted in cycles with the busy output high. An event
// in virtual mode takes one set-up cycle and nine pushes, and an event
// outside it takes set-up and three pushes. A refused gate ends after its
// first cycle with the fault flag set.
// A plain return, a flags push and a flags pop take one cycle each; a
// nested return and a task switch take two.
// A command written while busy is acknowledged and then dropped, so
// software must poll the busy bit before it issues the next command.
// The sequencer is written after the bus logic in the same process, so
// a register write that lands in a cycle where the sequencer updates the same register loses to it.
// Segment images are held as full words, but pushes and plain returns move
// only the low half. Pushed upper halves are zero, which keeps the stack image
// repeatable where the upper bits have no defined meaning.
// A selector counts as invalid on a return when its low two bits lie
// below the level in the popped code selector, and it is then replaced by a null selector.
// A software interrupt in virtual mode with I/O level 0 sets the fault
// flag and still takes the full gate exit, so the host can see it.
// A plain return into virtual mode always pops the outer stack pointer and
// segment, since the interrupted code ran at the outermost level.
module vrm_transition (
  input wire logic CLK_SYS, // Core clock, 100 MHz.
  input wire logic RESETN, // Asynchronous reset, active low.
  input wire logic [7:0] AWADDR, // Write address.
  input wire logic AWVALID, // Write address valid.
  output logic AWREADY, // Write address ready.
  input wire logic [31:0] WDATA, // Write data.
  input wire logic [3:0] WSTRB, // Write byte strobes.
  input wire logic WVALID, // Write data valid.
  output logic WREADY, // Write data ready.
  output logic [1:0] BRESP, // Write response.
  output logic BVALID, // Write response valid.
  input wire logic BREADY, // Write response ready.
  input wire logic [7:0] ARADDR, // Read address.
  input wire logic ARVALID, // Read address valid.
  output logic ARREADY, // Read address ready.
  output logic [31:0] RDATA, // Read data.
  output logic [1:0] RRESP, // Read response.
  output logic RVALID, // Read data valid.
  input wire logic RREADY, // Read data ready.
  output logic VIRTUAL_MODE, // Live mode flag.
  output logic BUSY // Sequence in progress.
);
  import vrm_pkg::*;

  core_t s;
  core_t next_s;

  // Handshakes are combinational; data comes from the state register.
  assign AWREADY = !s.aw_got;
  assign WREADY = !s.w_got;
  assign BVALID = s.bvalid;
  assign BRESP = s.berr ? `RESP_ERR : `RESP_OK;
  assign ARREADY = !s.rvalid;
  assign RVALID = s.rvalid;
  assign RRESP = s.rerr ? `RESP_ERR : `RESP_OK;
  assign RDATA = s.rdata;
  assign VIRTUAL_MODE = s.rf[`IDX_FLAGS][`FL_VM];
  assign BUSY = (s.st == ST_RUN);

  always_comb begin
    logic [31:0] word;
    logic [31:0] f;
    logic [31:0] sp;
    logic [31:0] nsp;
    logic [31:0] img;
    logic [31:0] pv;
    logic [31:0] gate;
    logic [2:0] cmd;
    logic [3:0] wi;
    logic [1:0] requested_priv_level;
    logic vm;
    logic newvm;
    word = 32'h00000000;
    f = s.rf[`IDX_FLAGS];
    sp = s.rf[`IDX_SP];
    nsp = 32'h00000000;
    img = 32'h00000000;
    pv = 32'h00000000;
    gate = s.rf[`IDX_GATE];
    cmd = s.rf[`IDX_CMD][2:0];
    wi = 4'h0;
    requested_priv_level = 2'h0;
    vm = f[`FL_VM];
    newvm = 1'b0;
    next_s = s;

    // Address and data channels are taken independently, either order.
    if (AWVALID && !s.aw_got) begin
      next_s.aw_got = 1'b1;
      next_s.aw_addr = AWADDR;
    end
    if (WVALID && !s.w_got) begin
      next_s.w_got = 1'b1;
      next_s.w_data = WDATA;
      next_s.w_strb = WSTRB;
    end
    if (s.bvalid && BREADY) begin
      next_s.bvalid = 1'b0;
    end

    // Commit a write once both halves are held and no response is pending.
    if (s.aw_got && s.w_got && !s.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.berr = s.aw_addr[`ADDR_ERR_BIT];
      wi = s.aw_addr[5:2];
      word = s.aw_addr[`ADDR_STACK_BIT] ? s.stk[wi] : s.rf[wi];
      for (int b = 0; b < 4; b++) begin
        if (s.w_strb[b]) begin
          word[8*b +: 8] = s.w_data[8*b +: 8];
        end
      end
      if (s.aw_addr[`ADDR_ERR_BIT]) begin
        word = 32'h00000000;
      end else if (s.aw_addr[`ADDR_STACK_BIT]) begin
        next_s.stk[wi] = word;
      end else if (wi == `IDX_STATUS) begin
        next_s.current_priv_level = word[1:0];
      end else if (wi == `IDX_CMD) begin
        // A command written while a sequence runs is dropped.
        if (s.st == ST_IDLE) begin
          next_s.rf[wi] = word;
          next_s.st = ST_RUN;
          next_s.step = 4'h0;
          next_s.fault = 1'b0;
        end
      end else begin
        next_s.rf[wi] = word;
      end
    end

    // Reads answer one cycle after the address is taken.
    if (s.rvalid && RREADY) begin
      next_s.rvalid = 1'b0;
    end
    if (ARVALID && !s.rvalid) begin
      wi = ARADDR[5:2];
      next_s.rvalid = 1'b1;
      next_s.rerr = ARADDR[`ADDR_ERR_BIT];
      if (ARADDR[`ADDR_ERR_BIT]) begin
        next_s.rdata = 32'h00000000;
      end else if (ARADDR[`ADDR_STACK_BIT]) begin
        next_s.rdata = s.stk[wi];
      end else if (wi == `IDX_STATUS) begin
        next_s.rdata = {26'h0000000, vm, s.st == ST_RUN, s.fault, vm,
                        s.current_priv_level};
      end else begin
        next_s.rdata = s.rf[wi];
      end
    end

    // The sequencer runs after the bus so that its updates win.
    if (s.st == ST_RUN) begin
      unique case (cmd)
        `CMD_EVENT, `CMD_SOFT_INT: begin
          if (s.step == 4'h0) begin
            if (cmd == `CMD_SOFT_INT && vm && f[`FL_IO_PRIV_LEVEL] == 2'h0) begin
              next_s.fault = 1'b1;
            end
            if (vm && (gate[`GATE_CONF] || gate[`GATE_DPL] != 2'h0)) begin
              next_s.fault = 1'b1;
              next_s.rf[`IDX_AUX] = {16'h0000, gate[`GATE_SEL]};
              next_s.st = ST_IDLE;
            end else begin
              next_s.tmp_flags = f;
              next_s.rf[`IDX_FLAGS][`FL_VM] = 1'b0;
              next_s.rf[`IDX_FLAGS][`FL_TF] = 1'b0;
              if (s.rf[`IDX_CMD][`CMD_INT_GATE]) begin
                next_s.rf[`IDX_FLAGS][`FL_IF] = 1'b0;
              end
              if (vm) begin
                next_s.old_ss = s.rf[`IDX_SS];
                next_s.old_sp = sp;
                next_s.rf[`IDX_SS] = s.rf[`IDX_L0_SS];
                next_s.rf[`IDX_SP] = s.rf[`IDX_L0_SP];
                next_s.current_priv_level = 2'h0;
                next_s.step = 4'h1;
              end else begin
                next_s.step = `PUSH_NONVM;
              end
            end
          end else begin
            unique case (s.step)
              4'h1: pv = {16'h0000, s.rf[`IDX_GS][15:0]};
              4'h2: pv = {16'h0000, s.rf[`IDX_FS][15:0]};
              4'h3: pv = {16'h0000, s.rf[`IDX_DS][15:0]};
              4'h4: pv = {16'h0000, s.rf[`IDX_ES][15:0]};
              4'h5: pv = {16'h0000, s.old_ss[15:0]};
              4'h6: pv = s.old_sp;
              4'h7: pv = s.tmp_flags;
              4'h8: pv = {16'h0000, s.rf[`IDX_CS][15:0]};
              default: pv = s.rf[`IDX_IP];
            endcase
            nsp = sp - `STK_STEP;
            next_s.rf[`IDX_SP] = nsp;
            next_s.stk[nsp[5:2]] = pv;
            next_s.step = s.step + 4'h1;
            if (s.step == `NULL_STEP) begin
              next_s.rf[`IDX_DS] = 32'h00000000;
              next_s.rf[`IDX_ES] = 32'h00000000;
              next_s.rf[`IDX_FS] = 32'h00000000;
              next_s.rf[`IDX_GS] = 32'h00000000;
            end
            if (s.step == `PUSH_LAST) begin
              next_s.rf[`IDX_CS] = {16'h0000, gate[`GATE_SEL]};
              next_s.rf[`IDX_IP] = s.rf[`IDX_GATE_IP];
              next_s.st = ST_IDLE;
            end
          end
        end
        `CMD_INTERRUPT_RETURN_INSTR: begin
          if (f[`FL_NT] || s.step != 4'h0) begin
            if (s.step == 4'h0) begin
              next_s.rf[`IDX_FLAGS] = s.rf[`IDX_AUX];
              next_s.step = 4'h1;
            end else begin
              next_s.st = ST_IDLE;
              if (s.rf[`IDX_FLAGS][`FL_VM]) begin
                next_s.current_priv_level = 2'h3;
              end
              for (int k = 0; k < 4; k++) begin
                next_s.rf[`IDX_DS + 4'(k)] = s.stk[`TASK_IMG_BASE + 4'(k)];
              end
            end
          end else begin
            img = s.stk[4'(sp[5:2] + 4'h2)];
            next_s.rf[`IDX_IP] = s.stk[sp[5:2]];
            next_s.rf[`IDX_CS] = {16'h0000, s.stk[4'(sp[5:2] + 4'h1)][15:0]};
            requested_priv_level = s.stk[4'(sp[5:2] + 4'h1)][1:0];
            if (s.rf[`IDX_CMD][`CMD_OP32] && s.current_priv_level == 2'h0 && !vm) begin
              next_s.rf[`IDX_FLAGS] = img;
            end else if (s.rf[`IDX_CMD][`CMD_OP32]) begin
              next_s.rf[`IDX_FLAGS] = {img[31:18], vm, img[16:0]};
            end else begin
              next_s.rf[`IDX_FLAGS] = {f[31:16], img[15:0]};
            end
            newvm = next_s.rf[`IDX_FLAGS][`FL_VM];
            nsp = sp + `STK_STEP + `STK_STEP + `STK_STEP;
            next_s.rf[`IDX_SP] = nsp;
            if (newvm) begin
              next_s.rf[`IDX_ES] = {16'h0000, s.stk[4'(nsp[5:2] + 4'h2)][15:0]};
              next_s.rf[`IDX_DS] = {16'h0000, s.stk[4'(nsp[5:2] + 4'h3)][15:0]};
              next_s.rf[`IDX_FS] = {16'h0000, s.stk[4'(nsp[5:2] + 4'h4)][15:0]};
              next_s.rf[`IDX_GS] = {16'h0000, s.stk[4'(nsp[5:2] + 4'h5)][15:0]};
            end else begin
              for (int k = 0; k < 4; k++) begin
                if (s.rf[`IDX_DS + 4'(k)][1:0] < requested_priv_level) begin
                  next_s.rf[`IDX_DS + 4'(k)] = 32'h00000000;
                end
              end
            end
            if (newvm || requested_priv_level > s.current_priv_level) begin
              next_s.rf[`IDX_SP] = s.stk[nsp[5:2]];
              next_s.rf[`IDX_SS] = {16'h0000, s.stk[4'(nsp[5:2] + 4'h1)][15:0]};
            end
            next_s.current_priv_level = newvm ? 2'h3 : (requested_priv_level > s.current_priv_level ? requested_priv_level : s.current_priv_level);
            next_s.st = ST_IDLE;
          end
        end
        `CMD_TASK: begin
          if (s.step == 4'h0) begin
            next_s.rf[`IDX_FLAGS] = s.rf[`IDX_AUX];
            next_s.step = 4'h1;
          end else begin
            for (int k = 0; k < 4; k++) begin
              next_s.rf[`IDX_DS + 4'(k)] = s.stk[`TASK_IMG_BASE + 4'(k)];
            end
            if (vm) begin
              next_s.current_priv_level = 2'h3;
            end
            next_s.st = ST_IDLE;
          end
        end
        `CMD_FLAGS_PUSH_INSTR: begin
          pv = {f[31:18], 1'b0, f[16:0]};
          nsp = sp - `STK_STEP;
          next_s.rf[`IDX_SP] = nsp;
          next_s.stk[nsp[5:2]] = pv;
          next_s.rf[`IDX_AUX] = pv;
          next_s.st = ST_IDLE;
        end
        `CMD_FLAGS_POP_INSTR: begin
          img = s.stk[sp[5:2]];
          next_s.rf[`IDX_FLAGS] = {img[31:18], vm, img[16:0]};
          next_s.rf[`IDX_SP] = sp + `STK_STEP;
          next_s.st = ST_IDLE;
        end
        default: begin
          // Unknown command codes simply end the sequence.
          next_s.st = ST_IDLE;
        end
      endcase
    end
  end

  // All state lives in one register; reset values are constants only.
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      s <= '0;
      s.rf[`IDX_FLAGS] <= `FLAGS_RST;
    end else begin
      s <= next_s;
    end
  end
endmodule

// ===== testbench/vrm_transition_sva.sv
`timescale 1ns/10ps
`include "vrm_regs.svh"
// Watches the register bus and the live mode flag from outside the block.
module vrm_transition_chk (
  input wire logic CLK_SYS, // Core clock.
  input wire logic RESETN, // Reset, active low.
  input wire logic [7:0] AWADDR, // Write address.
  input wire logic AWVALID, // Write address valid.
  input wire logic AWREADY, // Write address ready.
  input wire logic [31:0] WDATA, // Write data.
  input wire logic WVALID, // Write data valid.
  input wire logic WREADY, // Write data ready.
  input wire logic [1:0] BRESP, // Write response.
  input wire logic BVALID, // Write response valid.
  input wire logic BREADY, // Write response ready.
  input wire logic [7:0] ARADDR, // Read address.
  input wire logic ARVALID, // Read address valid.
  input wire logic ARREADY, // Read address ready.
  input wire logic [31:0] RDATA, // Read data.
  input wire logic [1:0] RRESP, // Read response.
  input wire logic RVALID, // Read data valid.
  input wire logic RREADY, // Read data ready.
  input wire logic VIRTUAL_MODE, // Live mode flag.
  input wire logic BUSY // Sequence running.
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESETN);
  // A flags pop command taken while idle; only it could touch the flag.
  sequence pop_taken;
    AWVALID && AWREADY && WVALID && WREADY && !BUSY && !BVALID &&
      AWADDR == 8'h00 && WDATA[2:0] == `CMD_FLAGS_POP_INSTR;
  endsequence
  // Bus answers come on time and stand until they are taken.
  chk_rd_latency: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read answer not one cycle after address");
  chk_rd_hold: assert property (RVALID && !RREADY |=>
    RVALID && $stable(RDATA) && $stable(RRESP))
    else $error("read answer dropped or changed before taken");
  chk_b_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped or changed before taken");
  chk_rd_release: assert property (RVALID && RREADY |=> !RVALID)
    else $error("read answer still valid after it was taken");
  chk_rd_unmapped: assert property (ARVALID && ARREADY && ARADDR[`ADDR_ERR_BIT]
    |=> RRESP == `RESP_ERR && RDATA == 32'h00000000)
    else $error("unmapped read not refused");
  chk_b_cause: assert property ($rose(BVALID) |->
    $past(AWVALID || !AWREADY) && $past(WVALID || !WREADY))
    else $error("write response without address and data");
  chk_mode_cause: assert property (
    !$stable(VIRTUAL_MODE) |-> $past(BUSY))
    else $error("mode flag changed outside a sequence");
  chk_pop_keeps: assert property (
    pop_taken |=> $stable(VIRTUAL_MODE) [*3])
    else $error("flags pop changed the mode flag");
  chk_busy_bound: assert property (
    $rose(BUSY) |-> ##[1:10] !BUSY)
    else $error("sequence longer than ten cycles");
  cover property ($rose(VIRTUAL_MODE));
  cover property ($fell(VIRTUAL_MODE));
  cover property (ARVALID && ARREADY && ARADDR[`ADDR_ERR_BIT]);
  cover property (RVALID && !RREADY);
endmodule
bind vrm_transition vrm_transition_chk vrm_transition_chk_i (.CLK_SYS,
  .RESETN, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WVALID, .WREADY, .BRESP,
  .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID,
  .RREADY, .VIRTUAL_MODE, .BUSY);

// ===== testbench/tb_top.sv
`timescale 1ns/10ps
`include "vrm_regs.svh"
// Compares a masked seen value with its note and counts the outcome.
`define CHK(a, e, s) begin n_checks++; if ((e) !== (s)) begin n_fail++; \
  $display("wrong value reg %h expected %h seen %h", a, e, s); end end
module tb_top;
  typedef struct {logic [7:0] a; logic [33:0] e; logic [33:0] m;} note_t;
  logic CLK_SYS = 1'b0;
  logic RESETN, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, VIRTUAL_MODE, BUSY;
  logic [7:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, g, gi, ls;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP;
  logic [31:0] seed = 32'h0000005B;
  logic [31:0] v [9];
  logic [3:0] ri [8] = '{`IDX_IP, `IDX_CS, `IDX_SP, `IDX_SS, `IDX_ES,
    `IDX_DS, `IDX_FS, `IDX_GS};
  int vi [8] = '{0, 1, 3, 4, 5, 6, 7, 8};
  int n_fail = 0;
  int n_checks = 0;
  int k;
  note_t q[$];
  note_t nt;
  always #5 CLK_SYS = ~CLK_SYS;
  vrm_transition vrm_transition_i (.CLK_SYS, .RESETN, .AWADDR, .AWVALID,
    .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY,
    .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY,
    .VIRTUAL_MODE, .BUSY);
  // Takes the oldest note whenever an answer is handed over.
  always @(posedge CLK_SYS) begin
    if ((RVALID && RREADY) || (BVALID && BREADY)) begin
      nt = q.pop_front();
      `CHK(nt.a, nt.e & nt.m,
        (RVALID ? {RRESP, RDATA} : {BRESP, 32'h0}) & nt.m)
    end
  end
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function logic [7:0] ra(input logic [3:0] i);
    return {2'b00, i, 2'b00};
  endfunction
  function logic [7:0] sa(input logic [3:0] i);
    return {2'b01, i, 2'b00};
  endfunction
  // Pointers whole, flag image on mode, step and enable bits, segments low half.
  function logic [31:0] msk(input int i);
    return i == 2 ? 32'h00020300 : (i == 0 || i == 3) ? 32'hFFFFFFFF :
      32'h0000FFFF;
  endfunction
  task wrap_up();
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task stuck();
    n_fail++;
    wrap_up();
  endtask
  // Address and data are offered together; each drops when it is taken.
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int i;
    q.push_back(note_t'{a, {r, 32'h0}, {2'b11, 32'h0}});
    @(posedge CLK_SYS);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    // A random late ready makes the slave hold its response.
    BREADY <= ^xs();
    for (i = 0; i < 64; i++) begin
      @(posedge CLK_SYS);
      if (AWREADY && AWVALID) AWVALID <= 1'b0;
      if (WREADY && WVALID) WVALID <= 1'b0;
      if (BVALID && BREADY) break;
      if (BVALID) BREADY <= 1'b1;
    end
    BREADY <= 1'b0;
    if (i == 64) stuck();
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
    input logic [1:0] r);
    int i;
    q.push_back(note_t'{a, {r, e}, {2'b11, m}});
    @(posedge CLK_SYS);
    ARADDR <= a;
    ARVALID <= 1'b1;
    // A random late ready makes the slave hold its answer.
    RREADY <= ^xs();
    for (i = 0; i < 64; i++) begin
      @(posedge CLK_SYS);
      if (ARREADY && ARVALID) ARVALID <= 1'b0;
      if (RVALID && RREADY) break;
      if (RVALID) RREADY <= 1'b1;
    end
    RREADY <= 1'b0;
    if (i == 64) stuck();
  endtask
  // Commits a command and waits, bounded, for the sequence to finish.
  task cmd(input logic [31:0] c);
    int i;
    wr(ra(`IDX_CMD), c, `RESP_OK);
    for (i = 0; i < 64 && BUSY !== 1'b0; i++) @(posedge CLK_SYS);
    if (i == 64) stuck();
  endtask
  task enter();
    wr(ra(`IDX_AUX), 32'h00020002, `RESP_OK);
    cmd(`CMD_TASK);
    rd(ra(`IDX_STATUS), 32'h24, 32'h24, `RESP_OK);
  endtask
  initial begin
    RESETN = 1'b0;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
    {AWADDR, ARADDR, WDATA} = 48'h0;
    WSTRB = 4'hF;
    repeat (5) @(posedge CLK_SYS);
    RESETN <= 1'b1;
    rd(ra(`IDX_FLAGS), `FLAGS_RST, 32'hFFFFFFFF, `RESP_OK);
    rd(ra(`IDX_STATUS), 32'h0, 32'h3F, `RESP_OK);
    rd(8'h80, 32'h0, 32'hFFFFFFFF, `RESP_ERR);
    wr(8'hC4, xs(), `RESP_ERR);
    // stack image with mode bit set, nested flag clear.
    wr(ra(`IDX_SP), 32'h0, `RESP_OK);
    for (k = 0; k < 9; k++) begin
      v[k] = xs();
      if (k == 2) v[k] = (v[k] | 32'h00020000) & ~32'h00004000;
      wr(sa(4'(k)), v[k], `RESP_OK);
    end
    cmd((32'h1 << `CMD_OP32) | `CMD_INTERRUPT_RETURN_INSTR);
    rd(ra(`IDX_STATUS), 32'h4, 32'h4, `RESP_OK);
    for (k = 0; k < 8; k++) begin
      rd(ra(ri[k]), v[vi[k]], msk(vi[k]), `RESP_OK);
    end
    cmd(`CMD_FLAGS_PUSH_INSTR);
    rd(ra(`IDX_AUX), 32'h0, 32'h00020000, `RESP_OK);
    wr(ra(`IDX_AUX), 32'h0, `RESP_OK);
    cmd(`CMD_FLAGS_POP_INSTR);
    rd(ra(`IDX_STATUS), 32'h4, 32'h4, `RESP_OK);
    // live step and enable bits set so the exit must clear them.
    v[2] = v[2] | 32'h00000300;
    wr(ra(`IDX_FLAGS), v[2], `RESP_OK);
    g = xs() & 32'h0000FFFF;
    gi = xs();
    ls = xs() & 32'h0000FFFF;
    wr(ra(`IDX_GATE), g, `RESP_OK);
    wr(ra(`IDX_GATE_IP), gi, `RESP_OK);
    wr(ra(`IDX_L0_SS), ls, `RESP_OK);
    wr(ra(`IDX_L0_SP), 32'h00000040, `RESP_OK);
    cmd((32'h1 << `CMD_INT_GATE) | `CMD_EVENT);
    rd(ra(`IDX_STATUS), 32'h0, 32'h4, `RESP_OK);
    rd(ra(`IDX_FLAGS), 32'h0, 32'h00020300, `RESP_OK);
    rd(ra(`IDX_IP), gi, 32'hFFFFFFFF, `RESP_OK);
    rd(ra(`IDX_CS), g, 32'h0000FFFF, `RESP_OK);
    rd(ra(`IDX_SS), ls, 32'h0000FFFF, `RESP_OK);
    rd(ra(`IDX_SP), 32'h0000001C, 32'hFFFFFFFF, `RESP_OK);
    for (k = 4; k < 8; k++) begin
      rd(ra(ri[k]), 32'h0, 32'h0000FFFF, `RESP_OK);
    end
    for (k = 0; k < 9; k++) begin
      rd(sa(4'(k + 7)), v[k], msk(k), `RESP_OK);
    end
    // popped image carries the mode bit.
    wr(sa(4'h7), 32'h00020000, `RESP_OK);
    cmd(`CMD_FLAGS_POP_INSTR);
    rd(ra(`IDX_STATUS), 32'h0, 32'h4, `RESP_OK);
    // nested return resumes the linked task image.
    wr(ra(`IDX_FLAGS), 32'h00004000, `RESP_OK);
    wr(ra(`IDX_AUX), 32'h00020002, `RESP_OK);
    cmd((32'h1 << `CMD_OP32) | `CMD_INTERRUPT_RETURN_INSTR);
    rd(ra(`IDX_STATUS), 32'h24, 32'h24, `RESP_OK);
    enter();
    cmd(`CMD_SOFT_INT);
    rd(ra(`IDX_STATUS), 32'h8, 32'hC, `RESP_OK);
    // one gate with raised level, one conforming.
    for (k = 0; k < 2; k++) begin
      enter();
      g = (xs() & 32'h0003FFFF) | (k == 0 ? 32'h00010000 : 32'h00040000);
      wr(ra(`IDX_GATE), g, `RESP_OK);
      cmd(`CMD_EVENT);
      rd(ra(`IDX_AUX), g, 32'h0000FFFF, `RESP_OK);
      rd(ra(`IDX_STATUS), 32'h8, 32'h8, `RESP_OK);
    end
    for (k = 0; k < 64 && q.size() > 0; k++) @(posedge CLK_SYS);
    if (q.size() > 0) n_fail++;
    wrap_up();
  end
endmodule
